// *** hdl/srcrc_ctrl.sv ***
`default_nettype none
`include "srcrc_cfg.svh"

module srcrc_ctrl #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire srcrc_pkg::srcrc_req_type ctrlReq,
  output logic [7:0] ctrlRdData,
  output logic ctrlRdValid,
  input wire logic [3:0] coreFrameRate,
  input wire logic rateTick,
  input wire srcrc_pkg::srcrc_pair_type adcPair,
  input wire srcrc_pkg::srcrc_pair_type [CHANNELS-1:0] coreSlots,
  output srcrc_pkg::srcrc_pair_type [CHANNELS-1:0] serialSlots,
  output srcrc_pkg::srcrc_pair_type adcToCore,
  output logic coreFrameStart,
  output logic coreAdvance,
  output logic coreStandby,
  output logic frameClkIsGpio,
  output logic bitClkIsGpio,
  output logic dataOutIsGpio,
  output logic dataInIsGpio,
  output logic [3:0] serialDivHalves,
  output logic serialRateReserved
);

  if (CHANNELS != 4) begin : gChk
    $error("srcrc_ctrl: CHANNELS must be 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [3:0] routeQ;
  logic [3:0] pinQ;
  logic runQ;
  logic [2:0] rateQ;
  logic wrRoute;
  logic wrPin;
  logic wrRun;
  logic wrRate;

  // Write decode
  assign wrRoute = ctrlReq.wr && ctrlReq.addr == `SRCRC_ADDR_ROUTE;
  assign wrPin = ctrlReq.wr && ctrlReq.addr == `SRCRC_ADDR_PIN;
  assign wrRun = ctrlReq.wr && ctrlReq.addr == `SRCRC_ADDR_RUN;
  assign wrRate = ctrlReq.wr && ctrlReq.addr == `SRCRC_ADDR_RATE;

  // Route select, any code kept readable
  // reserved code stored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      routeQ <= `SRCRC_ROUTE_RST;
    end else if (wrRoute) begin
      routeQ <= ctrlReq.data[3:0];
    end
  end

  // Pin function select
  // pins reset to serial
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinQ <= `SRCRC_PIN_RST;
    end else if (wrPin) begin
      pinQ <= ctrlReq.data[3:0];
    end
  end

  // Run bit
  // run clears on reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      runQ <= `SRCRC_RUN_RST;
    end else if (wrRun) begin
      runQ <= ctrlReq.data[`SRCRC_RUN_BIT];
    end
  end

  // Serial port rate
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rateQ <= `SRCRC_RATE_RST;
    end else if (wrRate) begin
      rateQ <= ctrlReq.data[2:0];
    end
  end

  // Read data, registered; unmapped and reserved bits read zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlRdData <= 8'h00;
      ctrlRdValid <= 1'b0;
    end else begin
      ctrlRdValid <= ctrlReq.rd;
      if (ctrlReq.rd) begin
        case (ctrlReq.addr)
          `SRCRC_ADDR_ROUTE: ctrlRdData <= {4'h0, routeQ};
          `SRCRC_ADDR_PIN: ctrlRdData <= {4'h0, pinQ};
          `SRCRC_ADDR_RUN: ctrlRdData <= {7'h00, runQ};
          `SRCRC_ADDR_RATE: ctrlRdData <= {5'h00, rateQ};
          default: ctrlRdData <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin functions

  // Pin mapping
  // bit one gives general line
  assign frameClkIsGpio = pinQ[`SRCRC_PIN_FRAME];
  assign bitClkIsGpio = pinQ[`SRCRC_PIN_BIT];
  assign dataOutIsGpio = pinQ[`SRCRC_PIN_DOUT];
  assign dataInIsGpio = pinQ[`SRCRC_PIN_DIN];

  ////////////////////////////////////////////////////////////////////////
  // Core run control

  srcrc_pkg::srcrc_run_type runState_q;
  logic frameLive;

  // Run and standby states follow the run bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      runState_q <= srcrc_pkg::SRCRC_STANDBY;
    end else begin
      case (runState_q)
        srcrc_pkg::SRCRC_STANDBY: begin
          if (runQ) runState_q <= srcrc_pkg::SRCRC_RUN;
        end
        srcrc_pkg::SRCRC_RUN: begin
          if (!runQ) runState_q <= srcrc_pkg::SRCRC_STANDBY;
        end
        default: runState_q <= srcrc_pkg::SRCRC_STANDBY;
      endcase
    end
  end

  // Frame pulse gating by frame-rate code
  // none codes block pulse
  assign frameLive = coreFrameRate < `SRCRC_FRAME_NONE_MIN;

  // Frame start and program counter advance, registered
  // advance per frame
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      coreFrameStart <= 1'b0;
      coreAdvance <= 1'b0;
    end else begin
      coreFrameStart <= rateTick && frameLive;
      coreAdvance <= rateTick && frameLive && runState_q == srcrc_pkg::SRCRC_RUN;
    end
  end

  assign coreStandby = runState_q != srcrc_pkg::SRCRC_RUN;

  ////////////////////////////////////////////////////////////////////////
  // Serial rate divisor

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serialDivHalves <= `SRCRC_DIV_1;
      serialRateReserved <= 1'b0;
    end else begin
      serialRateReserved <= rateQ == 3'h7;
      case (rateQ)
        3'h0: serialDivHalves <= `SRCRC_DIV_1;
        3'h1: serialDivHalves <= `SRCRC_DIV_6;
        3'h2: serialDivHalves <= `SRCRC_DIV_4;
        3'h3: serialDivHalves <= `SRCRC_DIV_3;
        3'h4: serialDivHalves <= `SRCRC_DIV_2;
        3'h5: serialDivHalves <= `SRCRC_DIV_1P5;
        3'h6: serialDivHalves <= `SRCRC_DIV_0P5;
        default: serialDivHalves <= `SRCRC_DIV_RSVD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output routing

  srcrc_route #(
    .CHANNELS(CHANNELS)
  ) uRoute (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .routeCode(routeQ),
    .adcPair(adcPair),
    .coreSlots(coreSlots),
    .slotsQ(serialSlots),
    .adcToCoreQ(adcToCore)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  pinWrite_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrPin |=> {frameClkIsGpio, bitClkIsGpio, dataOutIsGpio, dataInIsGpio} == $past(ctrlReq.data[3:0]))
    else $error("pin function not updated");
  coreAdv_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rateTick && frameLive && !coreStandby |=> coreAdvance)
    else $error("core did not advance on frame");
  runStop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrRun && !ctrlReq.data[0] |=> ##1 coreStandby && !coreAdvance)
    else $error("core not in standby after clear");
  runIdle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    coreAdvance |-> $past(runQ, 2))
    else $error("core advanced without run");
  frameNone_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    coreFrameRate >= `SRCRC_FRAME_NONE_MIN |=> !coreFrameStart)
    else $error("frame pulse under none code");
  rateSix_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wrRate && ctrlReq.data[2:0] == 3'h1 |=> ##1 serialDivHalves == 4'hc && !serialRateReserved)
    else $error("rate code 001 not divide by 6");
  runRead_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ctrlReq.rd && ctrlReq.addr == `SRCRC_ADDR_RUN |=> ctrlRdValid && ctrlRdData == {7'h00, $past(runQ)})
    else $error("run register read wrong");

endmodule : srcrc_ctrl

`default_nettype wire

// *** hdl/srcrc_cfg.svh ***
`ifndef SRCRC_CFG_SVH
`define SRCRC_CFG_SVH

// Control port register offsets
`define SRCRC_ADDR_ROUTE 16'h40f3
`define SRCRC_ADDR_PIN 16'h40f4
`define SRCRC_ADDR_RUN 16'h40f6
`define SRCRC_ADDR_RATE 16'h40f8

// Reset values
`define SRCRC_ROUTE_RST 4'h0
`define SRCRC_PIN_RST 4'h0
`define SRCRC_RUN_RST 1'b0
`define SRCRC_RATE_RST 3'h0

// Field positions
`define SRCRC_RUN_BIT 0
`define SRCRC_PIN_FRAME 3
`define SRCRC_PIN_BIT 2
`define SRCRC_PIN_DOUT 1
`define SRCRC_PIN_DIN 0

// Route code fields
`define SRCRC_ROUTE_CORE 4'h0
`define SRCRC_ROUTE_DIRECT 0
`define SRCRC_ROUTE_SWAP 3

// Frame-rate codes at and above this issue no frame pulse
`define SRCRC_FRAME_NONE_MIN 4'ha

// Serial rate divisor, counted in halves of a divide step
`define SRCRC_DIV_1 4'h2
`define SRCRC_DIV_6 4'hc
`define SRCRC_DIV_4 4'h8
`define SRCRC_DIV_3 4'h6
`define SRCRC_DIV_2 4'h4
`define SRCRC_DIV_1P5 4'h3
`define SRCRC_DIV_0P5 4'h1
`define SRCRC_DIV_RSVD 4'h0

// Sample width
`define SRCRC_SAMPLE_W 24

`endif

// *** hdl/srcrc_pkg.sv ***
`default_nettype none
`include "srcrc_cfg.svh"

package srcrc_pkg;

  // One stereo sample pair
  typedef struct packed {
    logic [`SRCRC_SAMPLE_W-1:0] left;
    logic [`SRCRC_SAMPLE_W-1:0] right;
  } srcrc_pair_type;

  // Control port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } srcrc_req_type;

  // Core run state, one-hot
  typedef enum logic [1:0] {
    SRCRC_STANDBY = 2'b01,
    SRCRC_RUN = 2'b10
  } srcrc_run_type;

endpackage : srcrc_pkg

`default_nettype wire

// *** hdl/srcrc_route.sv ***
`default_nettype none
`include "srcrc_cfg.svh"

module srcrc_route #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] routeCode,
  input wire srcrc_pkg::srcrc_pair_type adcPair,
  input wire srcrc_pkg::srcrc_pair_type [CHANNELS-1:0] coreSlots,
  output srcrc_pkg::srcrc_pair_type [CHANNELS-1:0] slotsQ,
  output srcrc_pkg::srcrc_pair_type adcToCoreQ
);

  // Channel index is two bits of the code
  if (CHANNELS != 4) begin : gChk
    $error("srcrc_route: CHANNELS must be 4");
  end

  logic isCore;
  logic isDirect;
  logic isSwap;
  logic [1:0] chSel;

  // Decode of the route code
  assign isCore = (routeCode == `SRCRC_ROUTE_CORE);
  assign isDirect = routeCode[`SRCRC_ROUTE_DIRECT];
  assign isSwap = routeCode[`SRCRC_ROUTE_SWAP];
  assign chSel = routeCode[2:1];

  // Converter feed into the core
  // core path feed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adcToCoreQ <= '0;
    end else begin
      adcToCoreQ <= isCore ? adcPair : '0;
    end
  end

  // Per-slot selection
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : gSlot
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        slotsQ[ch] <= '0;
      end else if (isCore) begin
        slotsQ[ch] <= coreSlots[ch];
      end else if (isDirect && !isSwap && chSel == 2'(ch)) begin
        slotsQ[ch] <= adcPair;
      end else if (isDirect && isSwap && chSel == 2'(ch)) begin
        slotsQ[ch].left <= adcPair.right;
        slotsQ[ch].right <= adcPair.left;
      end else begin
        slotsQ[ch] <= '0;
      end
    end
  end

  routeCore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    isCore |=> slotsQ == $past(coreSlots))
    else $error("core route slots mismatch");
  routeDirect_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    routeCode == 4'h3 |=> slotsQ[1] == $past(adcPair) && slotsQ[0] == '0)
    else $error("direct route to channel 1 wrong");
  routeSwap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    routeCode == 4'hf |=> slotsQ[3].right == $past(adcPair.left) && slotsQ[3].left == $past(adcPair.right))
    else $error("swapped route to channel 3 wrong");
  routeReserved_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !isCore && !isDirect |=> slotsQ == '0 && adcToCoreQ == '0)
    else $error("reserved route code drove data");

endmodule : srcrc_route

`default_nettype wire

// *** dv/srcrc_ctrl_test.sv ***
`default_nettype none
`include "srcrc_cfg.svh"

module srcrc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [47:0] ADC_VAL = 48'h123456_abcdef;

  logic sys_clk;
  logic nrst;
  srcrc_pkg::srcrc_req_type ctrlReq;
  logic [7:0] ctrlRdData;
  logic ctrlRdValid;
  logic [3:0] coreFrameRate;
  logic rateTick;
  srcrc_pkg::srcrc_pair_type adcPair;
  srcrc_pkg::srcrc_pair_type [3:0] coreSlots;
  srcrc_pkg::srcrc_pair_type [3:0] serialSlots;
  srcrc_pkg::srcrc_pair_type adcToCore;
  logic coreFrameStart;
  logic coreAdvance;
  logic coreStandby;
  logic frameClkIsGpio;
  logic bitClkIsGpio;
  logic dataOutIsGpio;
  logic dataInIsGpio;
  logic [3:0] serialDivHalves;
  logic serialRateReserved;
  int nErrors = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [3:0] divTab [8] = '{4'h2, 4'hc, 4'h8, 4'h6, 4'h4, 4'h3, 4'h1, 4'h0};

  srcrc_ctrl #(.CHANNELS(4)) dut_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ctrlReq(ctrlReq),
    .ctrlRdData(ctrlRdData),
    .ctrlRdValid(ctrlRdValid),
    .coreFrameRate(coreFrameRate),
    .rateTick(rateTick),
    .adcPair(adcPair),
    .coreSlots(coreSlots),
    .serialSlots(serialSlots),
    .adcToCore(adcToCore),
    .coreFrameStart(coreFrameStart),
    .coreAdvance(coreAdvance),
    .coreStandby(coreStandby),
    .frameClkIsGpio(frameClkIsGpio),
    .bitClkIsGpio(bitClkIsGpio),
    .dataOutIsGpio(dataOutIsGpio),
    .dataInIsGpio(dataInIsGpio),
    .serialDivHalves(serialDivHalves),
    .serialRateReserved(serialRateReserved)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and close
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (nErrors == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // Control port cycles, one-cycle strobes
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ctrlReq.wr <= 1'b1;
    ctrlReq.addr <= a;
    ctrlReq.data <= d;
    @(posedge sys_clk);
    ctrlReq.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    ctrlReq.rd <= 1'b1;
    ctrlReq.addr <= a;
    @(posedge sys_clk);
    ctrlReq.rd <= 1'b0;
    #1;
    check(ctrlRdValid, 1'b1);
    check(ctrlRdData, exp);
  endtask : rd_check

  // Frame tick, then look at both pulses
  task automatic tick(input logic [3:0] f, input logic [1:0] exp);
    @(posedge sys_clk);
    rateTick <= 1'b1;
    coreFrameRate <= f;
    @(posedge sys_clk);
    rateTick <= 1'b0;
    #1;
    check({coreFrameStart, coreAdvance}, exp);
  endtask : tick

  // Expected slot content for a route code
  function automatic logic [47:0] exp_slot(input logic [3:0] code, input int i);
    if (code == 4'h0) begin
      return coreSlots[i];
    end
    if (code[0] && i == int'(code[2:1])) begin
      return code[3] ? {ADC_VAL[23:0], ADC_VAL[47:24]} : ADC_VAL;
    end
    return 48'h0;
  endfunction : exp_slot

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    ctrlReq = '0;
    coreFrameRate = 4'h0;
    rateTick = 1'b0;
    adcPair = ADC_VAL;
    for (int i = 0; i < 4; i++) begin
      coreSlots[i] = {24'hc00000 + 24'(i), 24'hd00000 + 24'(i)};
    end
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset state and unmapped read
    rd_check(`SRCRC_ADDR_PIN, 8'h00);
    rd_check(`SRCRC_ADDR_RUN, 8'h00);
    rd_check(`SRCRC_ADDR_RATE, 8'h00);
    rd_check(`SRCRC_ADDR_ROUTE, 8'h00);
    rd_check(16'h40f5, 8'h00);
    check(coreStandby, 1'b1);
    check(serialDivHalves, 4'h2);
    // Every route code, reserved upper bits written too
    for (int c = 0; c < 16; c++) begin
      wr_reg(`SRCRC_ADDR_ROUTE, {4'hf, 4'(c)});
      repeat (2) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 4; i++) begin
        check(serialSlots[i], exp_slot(4'(c), i));
      end
      check(adcToCore, (c == 0) ? ADC_VAL : 48'h0);
      rd_check(`SRCRC_ADDR_ROUTE, {4'h0, 4'(c)});
    end
    // Each pin bit alone, then all bits
    for (int b = 0; b < 5; b++) begin
      wr_reg(`SRCRC_ADDR_PIN, (b < 4) ? (8'h01 << b) : 8'hff);
      @(posedge sys_clk);
      #1;
      check({frameClkIsGpio, bitClkIsGpio, dataOutIsGpio, dataInIsGpio}, (b < 4) ? (4'h1 << b) : 4'hf);
      rd_check(`SRCRC_ADDR_PIN, (b < 4) ? (8'h01 << b) : 8'h0f);
    end
    // Every rate code
    for (int r = 0; r < 8; r++) begin
      wr_reg(`SRCRC_ADDR_RATE, {5'h1f, 3'(r)});
      repeat (2) @(posedge sys_clk);
      #1;
      check(serialDivHalves, divTab[r]);
      check(serialRateReserved, r == 7);
      rd_check(`SRCRC_ADDR_RATE, {5'h00, 3'(r)});
    end
    // Start: serial rate matched to frame rate, valid frame rate first, then run
    wr_reg(`SRCRC_ADDR_RATE, 8'h00);
    coreFrameRate <= 4'h1;
    wr_reg(`SRCRC_ADDR_RUN, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1;
    check(coreStandby, 1'b0);
    check(serialDivHalves, 4'h2);
    rd_check(`SRCRC_ADDR_RUN, 8'h01);
    tick(4'h1, 2'b11);
    // No frame pulse for the none codes
    for (int f = 10; f < 16; f++) begin
      tick(4'(f), 2'b00);
    end
    // Standby with frame rate at none; settle wait shortened, the block does not time it
    wr_reg(`SRCRC_ADDR_RUN, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    check(coreStandby, 1'b1);
    tick(4'h1, 2'b10);
    // Restart
    wr_reg(`SRCRC_ADDR_RUN, 8'h01);
    repeat (2) @(posedge sys_clk);
    tick(4'h1, 2'b11);
    // Reset in mid-run returns run and pin registers to default
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    check(coreStandby, 1'b1);
    check({frameClkIsGpio, bitClkIsGpio, dataOutIsGpio, dataInIsGpio}, 4'h0);
    rd_check(`SRCRC_ADDR_RUN, 8'h00);
    rd_check(`SRCRC_ADDR_PIN, 8'h00);
    tally_and_finish();
  end

endmodule : srcrc_ctrl_test

`default_nettype wire
